// >>> dv/dcm_host_model.sv
`timescale 1ns/100ps
// ==========================================================
// Host model: one command word per request
// ==========================================================
module dcm_host_model (
    // Clock
    input wire logic core_clk,
    // Command towards the block
    output logic cmd_valid,
    output dcm_pkg::dcm_cmd_t cmd,
    // Readback from the block
    input wire logic rd_valid,
    input wire logic [11:0] rd_data
);
    import dcm_pkg::*;

    logic [11:0] last_rd;

    initial
    begin
        cmd_valid = 1'b0;
        cmd = '0;
        last_rd = '0;
    end

    // Called just after a rising edge; one idle edge, then the word stands for one edge
    task automatic send(input logic rw, input logic [1:0] sel, input logic [5:0] addr,
        input logic [11:0] data);
        @(posedge core_clk);
        #1;
        last_rd = 'x;
        cmd = {rw, sel, addr, data};
        cmd_valid = 1'b1;
        @(posedge core_clk);
        #1;
        cmd_valid = 1'b0;
        // Released word no longer shows its last value
        cmd = ~cmd;
        if (rd_valid === 1'b1)
        begin
            last_rd = rd_data;
        end
    endtask : send
endmodule : dcm_host_model

// >>> dv/testbench.sv
`timescale 1ns/100ps
// ==========================================================
// Testbench
// ==========================================================
module testbench;
    import dcm_pkg::*;

    localparam int SR_CYCLES = 10;
    localparam logic [11:0] DEF = DCM_CTRL_RESET | 12'h400;

    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic hw_powerdown_pin = 1'b0;
    logic over_temp_pin = 1'b0;
    logic load_dac_strobe_n = 1'b1;
    logic cmd_valid;
    dcm_cmd_t cmd;
    logic rd_valid, busy_n, clear_all_pulse, amps_on, monitor_route, monitor_output_pin_hiz;
    logic [11:0] rd_data;
    dcm_cfg_t cfg;
    logic [4:0] toggle_phase;
    logic [5:0] monitor_channel;
    int n_mismatch = 0;
    int num_checks = 0;
    logic [11:0] d;
    logic [5:0] ch;
    int n;

    always #2.5 core_clk = ~core_clk;

    dcm_sfr #(.SOFT_RESET_CYCLES(SR_CYCLES), .REF_LEVEL_DEFAULT(1'b1)) i_dcm_sfr (
        .core_clk(core_clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd(cmd),
        .hw_powerdown_pin(hw_powerdown_pin), .over_temp_pin(over_temp_pin),
        .load_dac_strobe_n(load_dac_strobe_n), .rd_valid(rd_valid), .rd_data(rd_data),
        .busy_n(busy_n), .clear_all_pulse(clear_all_pulse), .cfg(cfg), .amps_on(amps_on),
        .toggle_phase(toggle_phase), .monitor_channel(monitor_channel),
        .monitor_route(monitor_route), .monitor_output_pin_hiz(monitor_output_pin_hiz));

    dcm_host_model i_dcm_host_model (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd(cmd),
        .rd_valid(rd_valid), .rd_data(rd_data));

    function automatic logic [11:0] exp_cfg(input logic [11:0] v);
        return {1'b0, v[11:6], v[4:0]};
    endfunction : exp_cfg

    task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test

    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask : cyc

    task automatic sfr(input logic [5:0] a, input logic [11:0] v);
        i_dcm_host_model.send(1'b0, 2'b00, a, v);
    endtask : sfr

    task automatic rd_ctrl(input logic [11:0] exp);
        i_dcm_host_model.send(1'b1, 2'b00, DCM_CMD_DEVICE_CONTROL, 12'($urandom));
        check("rd_data", i_dcm_host_model.last_rd & 12'hfdf, exp);
    endtask : rd_ctrl

    initial
    begin
        void'($urandom(9639));
        cyc(4);
        rstn = 1'b1;
        // ==========================================================
        // Defaults
        // ==========================================================
        check("cfg", cfg, exp_cfg(DEF));
        check("toggle_phase", toggle_phase, 0);
        check("monitor_channel", monitor_channel, 0);
        rd_ctrl(DEF);
        // ==========================================================
        // Control write and read, corners then random
        // ==========================================================
        for (int i = 0; i < 10; i++)
        begin
            d = (i == 0) ? 12'hfff : (i == 1) ? 12'h000 : 12'($urandom);
            d[5] = 1'b0;
            sfr(DCM_CMD_DEVICE_CONTROL, d);
            check("cfg", cfg, exp_cfg(d));
            rd_ctrl(d);
        end
        for (int s = 1; s < 4; s++)
        begin
            i_dcm_host_model.send(1'b0, 2'(s), DCM_CMD_DEVICE_CONTROL, ~d);
            check("cfg", cfg, exp_cfg(d));
        end
        // ==========================================================
        // Monitor routing
        // ==========================================================
        sfr(DCM_CMD_DEVICE_CONTROL, 12'h800);
        sfr(DCM_CMD_MONITOR_CHANNEL_SELECT, {6'h05, 6'h3f});
        check("monitor_route", monitor_route, 0);
        sfr(DCM_CMD_DEVICE_CONTROL, 12'h880);
        for (int i = 0; i < 6; i++)
        begin
            ch = (i == 0) ? 6'h00 : (i == 1) ? DCM_MON_LAST_DEFINED :
                (i == 2) ? DCM_MON_THREE_STATE : 6'($urandom_range(38));
            sfr(DCM_CMD_MONITOR_CHANNEL_SELECT, {ch, 6'($urandom)});
            check("monitor_channel", monitor_channel, ch);
            check("monitor_route", monitor_route, ch != 6'h3f);
            check("monitor_hiz", monitor_output_pin_hiz, ch == 6'h3f);
        end
        // ==========================================================
        // Toggle groups follow load strobe
        // ==========================================================
        sfr(DCM_CMD_DEVICE_CONTROL, 12'h015);
        for (int i = 1; i < 3; i++)
        begin
            load_dac_strobe_n = 1'b0;
            cyc(6);
            load_dac_strobe_n = 1'b1;
            cyc(2);
            check("toggle_phase", toggle_phase, (i % 2) ? 5'h15 : 5'h00);
        end
        // ==========================================================
        // Power-down refuses writes
        // ==========================================================
        sfr(DCM_CMD_POWER_DOWN, 12'($urandom));
        check("amps_on", amps_on, 0);
        sfr(DCM_CMD_DEVICE_CONTROL, 12'hfdf);
        check("cfg", cfg, exp_cfg(12'h015));
        sfr(DCM_CMD_POWER_UP, 12'($urandom));
        cyc(1);
        check("amps_on", amps_on, 1);
        hw_powerdown_pin = 1'b1;
        cyc(4);
        check("amps_on", amps_on, 0);
        sfr(DCM_CMD_DEVICE_CONTROL, 12'hfdf);
        check("cfg", cfg, exp_cfg(12'h015));
        sfr(DCM_CMD_POWER_DOWN, 12'($urandom));
        hw_powerdown_pin = 1'b0;
        cyc(4);
        check("amps_on", amps_on, 1);
        // ==========================================================
        // Thermal guard
        // ==========================================================
        sfr(DCM_CMD_DEVICE_CONTROL, 12'h840);
        over_temp_pin = 1'b1;
        cyc(6);
        check("amps_on", amps_on, 0);
        sfr(DCM_CMD_POWER_UP, 12'h000);
        cyc(1);
        check("amps_on", amps_on, 0);
        over_temp_pin = 1'b0;
        cyc(6);
        sfr(DCM_CMD_POWER_UP, 12'h000);
        cyc(1);
        check("amps_on", amps_on, 1);
        // ==========================================================
        // Soft reset
        // ==========================================================
        sfr(DCM_CMD_DEVICE_CONTROL, 12'h2df);
        sfr(DCM_CMD_SOFT_RESET, 12'($urandom));
        check("busy_n", busy_n, 0);
        check("clear_all_pulse", clear_all_pulse, 1);
        check("cfg", cfg, exp_cfg(DEF));
        sfr(DCM_CMD_DEVICE_CONTROL, 12'h0df);
        // Two edges since the reset command was taken
        n = 2;
        while (busy_n !== 1'b1 && n < 100)
        begin
            cyc(1);
            n++;
        end
        check("busy_cycles", 12'(n), 12'(SR_CYCLES));
        check("cfg", cfg, exp_cfg(DEF));
        check("monitor_channel", monitor_channel, 0);
        rd_ctrl(DEF);
        finish_test();
    end
endmodule : testbench

// >>> verilog/dcm_pkg.sv
package dcm_pkg;

    // ==========================================================
    // Register select and command addresses
    // ==========================================================
    localparam logic [5:0] DCM_CMD_NOP = 6'h00;
    localparam logic [5:0] DCM_CMD_POWER_DOWN = 6'h08;
    localparam logic [5:0] DCM_CMD_POWER_UP = 6'h09;
    localparam logic [5:0] DCM_CMD_MONITOR_CHANNEL_SELECT = 6'h0a;
    localparam logic [5:0] DCM_CMD_DEVICE_CONTROL = 6'h0c;
    localparam logic [5:0] DCM_CMD_SOFT_RESET = 6'h0f;

    // ==========================================================
    // Control register fields
    // ==========================================================
    localparam int DCM_BIT_POWERDOWN_OUTPUT_STATE = 11;
    localparam int DCM_BIT_REFERENCE_LEVEL_SELECT = 10;
    localparam int DCM_BIT_AMPLIFIER_BOOST = 9;
    localparam int DCM_BIT_REFERENCE_SOURCE_SELECT = 8;
    localparam int DCM_BIT_MONITOR_ENABLE = 7;
    localparam int DCM_BIT_THERMAL_GUARD_ENABLE = 6;
    localparam int DCM_BIT_UNUSED_CONTROL = 5;
    localparam int DCM_GROUPS = 5;
    localparam logic [11:0] DCM_CTRL_RESET = 12'h800;
    localparam logic [5:0] DCM_MON_RESET = 6'h00;
    localparam logic [5:0] DCM_MON_THREE_STATE = 6'h3f;
    localparam logic [5:0] DCM_MON_LAST_DEFINED = 6'h26;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int DCM_CLK_PERIOD_PS = 5000;
    localparam int DCM_SOFT_RESET_US = 135;
    localparam int DCM_SOFT_RESET_CYCLES = (DCM_SOFT_RESET_US * 1000000) / DCM_CLK_PERIOD_PS;
    localparam logic [14:0] DCM_CNT_ZERO = 15'h0000;

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic rd_wr;
        logic register_select_high;
        logic register_select_low;
        logic [5:0] addr;
        logic [11:0] data;
    } dcm_cmd_t;

    typedef struct packed {
        logic powerdown_output_state;
        logic reference_level_select;
        logic amplifier_boost;
        logic reference_source_select;
        logic monitor_enable;
        logic thermal_guard_enable;
        logic [4:0] toggle_group_enables;
    } dcm_cfg_t;

    typedef struct packed {
        logic [11:0] ctrl;
        logic [5:0] mon_sel;
        logic soft_pd;
        logic thermal_shut;
        logic amps_on;
        logic resetting;
        logic [14:0] busy_cnt;
        logic reset_pulse;
        logic [4:0] toggle_phase;
        logic rd_valid;
        logic [11:0] rd_data;
        logic [1:0] hw_pd_sync;
        logic hw_pd_prev;
        logic [1:0] hot_sync;
        logic [1:0] ld_sync;
        logic ld_prev;
        logic busy_n;
        logic mon_route;
        logic mon_hiz;
    } dcm_state_t;

endpackage : dcm_pkg

// >>> verilog/dcm_sfr.sv
// Behaviour
// [RL1] Command 001111 in special space is soft reset; data bits ignored.
// [RL2] Soft reset restores all defaults and pulses a clear to coefficients and DACs.
// [RL3] Soft reset keeps the block busy for 135 us.
// [RL4] Command 001100 writes control when read/write is 0, reads it when 1.
// [RL5] Bit 11 picks power-down output: 1 high impedance (default), 0 load.
// [RL6] Bit 10 picks reference level 2.5 V or 1.25 V; default per variant.
// [RL7] Bit 9 turns amplifier boost on; default off.
// [RL8] Bit 8 selects internal reference when 1; default external.
// [RL9] Bit 7 enables monitor; when 0 the pin is a normal channel output.
// [RL10] With monitor on, monitor command routes chosen channel to last channel pin.
// [RL11] Bit 6 set: over-temperature powers down all output amplifiers.
// [RL12] After thermal shutdown, power-up re-enables amplifiers only when cool.
// [RL13] Bit 6 resets to 0; bit 5 is don't care.
// [RL14] Bits 4..0 enable toggle for eight-channel groups, bit k channels 8k..8k+7.
// [RL15] Toggle groups swap between A and B codes on each load strobe.
// [RL16] Command 001010 takes channel from data 11..6, ignores data 5..0.
// [RL17] Host enables monitor before issuing monitor channel commands.
// [RL18] Channels 0..38 route the channel, 63 three-states, 39..62 undefined.
// [RL19] Special commands decode only with both register selects at 0.
// [RL20] Writes ignored in power-down; exit by power-up or hardware release.
// [RL21] Toggle enables and monitor select reset to 0; busy held during reset.
`timescale 1ns/100ps
module dcm_sfr #(
    parameter int SOFT_RESET_CYCLES = dcm_pkg::DCM_SOFT_RESET_CYCLES,
    parameter logic REF_LEVEL_DEFAULT = 1'b1
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Decoded command from the interface
    input wire logic cmd_valid,
    input wire dcm_pkg::dcm_cmd_t cmd,
    // Pins
    input wire logic hw_powerdown_pin,
    input wire logic over_temp_pin,
    input wire logic load_dac_strobe_n,
    // Readback
    output logic rd_valid,
    output logic [11:0] rd_data,
    // Status and controls
    output logic busy_n,
    output logic clear_all_pulse,
    output dcm_pkg::dcm_cfg_t cfg,
    output logic amps_on,
    output logic [4:0] toggle_phase,
    output logic [5:0] monitor_channel,
    output logic monitor_route,
    output logic monitor_output_pin_hiz
);
    import dcm_pkg::*;

    localparam logic [11:0] CTRL_DEFAULT = DCM_CTRL_RESET
        | (12'(REF_LEVEL_DEFAULT) << DCM_BIT_REFERENCE_LEVEL_SELECT);
    localparam logic [14:0] RESET_LOAD = 15'(SOFT_RESET_CYCLES - 1);

    dcm_state_t state_reg;
    dcm_state_t state_next;

    function automatic logic is_cmd(input dcm_cmd_t c, input logic [5:0] code);
        is_cmd = !c.register_select_high && !c.register_select_low && c.addr == code;
    endfunction : is_cmd

    // ==========================================================
    // Next state
    // ==========================================================
    logic hw_pd;
    logic hot;
    logic ld_fall;
    logic take;
    logic pd_now;
    always_comb
    begin
        state_next = state_reg;
        hw_pd = state_reg.hw_pd_sync[1];
        hot = state_reg.hot_sync[1];
        ld_fall = state_reg.ld_prev && !state_reg.ld_sync[1];
        take = cmd_valid && !state_reg.resetting;
        pd_now = state_reg.soft_pd || hw_pd;
        state_next.hw_pd_sync = {state_reg.hw_pd_sync[0], hw_powerdown_pin};
        state_next.hot_sync = {state_reg.hot_sync[0], over_temp_pin};
        state_next.ld_sync = {state_reg.ld_sync[0], load_dac_strobe_n};
        state_next.hw_pd_prev = hw_pd;
        state_next.ld_prev = state_reg.ld_sync[1];
        state_next.rd_valid = 1'b0;
        state_next.reset_pulse = 1'b0;
        // Leaving hardware power-down also leaves soft power-down
        if (state_reg.hw_pd_prev && !hw_pd)
        begin
            state_next.soft_pd = 1'b0; // [RL20]
        end
        // Soft reset countdown
        if (state_reg.resetting)
        begin
            if (state_reg.busy_cnt == DCM_CNT_ZERO)
            begin
                state_next.resetting = 1'b0; // [RL3]
            end
            else
            begin
                state_next.busy_cnt = state_reg.busy_cnt - 15'h0001; // [RL21]
            end
        end
        // Toggle groups flip on load strobe while not busy
        if (ld_fall && !state_reg.resetting)
        begin
            state_next.toggle_phase = state_reg.toggle_phase
                ^ state_reg.ctrl[DCM_GROUPS-1:0]; // [RL14] [RL15]
        end
        // Command decode
        if (take)
        begin
            if (is_cmd(cmd, DCM_CMD_SOFT_RESET) && !pd_now) // [RL1] [RL19]
            begin
                state_next.ctrl = CTRL_DEFAULT; // [RL2] [RL5] [RL6] [RL7] [RL8] [RL13]
                state_next.mon_sel = DCM_MON_RESET; // [RL21]
                state_next.toggle_phase = 5'h00;
                state_next.thermal_shut = 1'b0;
                state_next.reset_pulse = 1'b1; // [RL2]
                state_next.resetting = 1'b1; // [RL3]
                state_next.busy_cnt = RESET_LOAD;
            end
            else if (is_cmd(cmd, DCM_CMD_DEVICE_CONTROL) && cmd.rd_wr) // [RL4]
            begin
                state_next.rd_valid = 1'b1;
                state_next.rd_data = state_reg.ctrl;
            end
            else if (is_cmd(cmd, DCM_CMD_DEVICE_CONTROL) && !pd_now) // [RL4] [RL20]
            begin
                state_next.ctrl = cmd.data;
            end
            else if (is_cmd(cmd, DCM_CMD_MONITOR_CHANNEL_SELECT) && !cmd.rd_wr
                && !pd_now) // [RL16] [RL19] [RL20]
            begin
                state_next.mon_sel = cmd.data[11:6]; // [RL16]
            end
            else if (is_cmd(cmd, DCM_CMD_POWER_DOWN) && !cmd.rd_wr)
            begin
                state_next.soft_pd = 1'b1;
            end
            else if (is_cmd(cmd, DCM_CMD_POWER_UP) && !cmd.rd_wr)
            begin
                state_next.soft_pd = 1'b0; // [RL20]
                if (!hot)
                begin
                    state_next.thermal_shut = 1'b0; // [RL12]
                end
            end
        end
        // Thermal guard last, so a hot event wins over any clear
        if (state_reg.ctrl[DCM_BIT_THERMAL_GUARD_ENABLE] && hot)
        begin
            state_next.thermal_shut = 1'b1; // [RL11]
        end
        state_next.amps_on = !(state_next.soft_pd || hw_pd
            || state_next.thermal_shut); // [RL11]
        state_next.busy_n = !state_next.resetting; // [RL21]
        state_next.mon_route = state_next.ctrl[DCM_BIT_MONITOR_ENABLE]
            && state_next.mon_sel != DCM_MON_THREE_STATE; // [RL9] [RL10] [RL18]
        state_next.mon_hiz = state_next.ctrl[DCM_BIT_MONITOR_ENABLE]
            && state_next.mon_sel == DCM_MON_THREE_STATE; // [RL18]
    end

    // ==========================================================
    // State register
    // ==========================================================
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= '0;
            state_reg.ctrl <= CTRL_DEFAULT; // [RL13] [RL21]
            state_reg.amps_on <= 1'b1;
            state_reg.ld_sync <= 2'h3;
            state_reg.ld_prev <= 1'b1;
            state_reg.busy_n <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign rd_valid = state_reg.rd_valid;
    assign rd_data = state_reg.rd_data;
    assign busy_n = state_reg.busy_n; // [RL21]
    assign clear_all_pulse = state_reg.reset_pulse;
    assign cfg.powerdown_output_state = state_reg.ctrl[DCM_BIT_POWERDOWN_OUTPUT_STATE]; // [RL5]
    assign cfg.reference_level_select = state_reg.ctrl[DCM_BIT_REFERENCE_LEVEL_SELECT]; // [RL6]
    assign cfg.amplifier_boost = state_reg.ctrl[DCM_BIT_AMPLIFIER_BOOST]; // [RL7]
    assign cfg.reference_source_select = state_reg.ctrl[DCM_BIT_REFERENCE_SOURCE_SELECT]; // [RL8]
    assign cfg.monitor_enable = state_reg.ctrl[DCM_BIT_MONITOR_ENABLE]; // [RL9]
    assign cfg.thermal_guard_enable = state_reg.ctrl[DCM_BIT_THERMAL_GUARD_ENABLE]; // [RL13]
    assign cfg.toggle_group_enables = state_reg.ctrl[DCM_GROUPS-1:0]; // [RL14]
    assign amps_on = state_reg.amps_on;
    assign toggle_phase = state_reg.toggle_phase;
    assign monitor_channel = state_reg.mon_sel;
    assign monitor_route = state_reg.mon_route; // [RL9] [RL10]
    assign monitor_output_pin_hiz = state_reg.mon_hiz; // [RL18]

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    logic chk_reset_cmd;
    logic chk_wr_cmd;
    logic chk_rd_cmd;
    logic chk_mon_cmd;
    assign chk_reset_cmd = cmd_valid && busy_n && is_cmd(cmd, DCM_CMD_SOFT_RESET)
        && !state_reg.soft_pd && !state_reg.hw_pd_sync[1];
    assign chk_wr_cmd = cmd_valid && busy_n && is_cmd(cmd, DCM_CMD_DEVICE_CONTROL)
        && !cmd.rd_wr && !state_reg.soft_pd && !state_reg.hw_pd_sync[1];
    assign chk_rd_cmd = cmd_valid && busy_n && is_cmd(cmd, DCM_CMD_DEVICE_CONTROL) && cmd.rd_wr;
    assign chk_mon_cmd = cmd_valid && busy_n && !cmd.rd_wr
        && is_cmd(cmd, DCM_CMD_MONITOR_CHANNEL_SELECT)
        && !state_reg.soft_pd && !state_reg.hw_pd_sync[1];

    // ==========================================================
    // Busy window length
    // ==========================================================
    logic [14:0] chk_busy_len;
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            chk_busy_len <= 15'h0000;
        end
        else if (!busy_n)
        begin
            chk_busy_len <= chk_busy_len + 15'h0001;
        end
        else
        begin
            chk_busy_len <= 15'h0000;
        end
    end

    a_soft_reset_default: assert property (chk_reset_cmd |=> clear_all_pulse // [RL2]
        && state_reg.ctrl == CTRL_DEFAULT && monitor_channel == DCM_MON_RESET
        && toggle_phase == 5'h00)
        else $error("soft reset did not restore defaults");
    a_soft_reset_busy: assert property (chk_reset_cmd |=> !busy_n [*8]) // [RL3]
        else $error("busy released early in soft reset");
    a_busy_count: assert property ($rose(busy_n) // [RL3]
        |-> $past(state_reg.busy_cnt) == DCM_CNT_ZERO)
        else $error("busy ended before count expired");
    a_busy_length: assert property ($rose(busy_n) // [RL3]
        |-> chk_busy_len == 15'(SOFT_RESET_CYCLES))
        else $error("busy low time differs from soft reset count");
    a_busy_refuse: assert property (!busy_n && cmd_valid // [RL3]
        |=> $stable(state_reg.ctrl) && $stable(monitor_channel))
        else $error("command taken while busy");
    a_sel_refuse: assert property (cmd_valid // [RL19]
        && (cmd.register_select_high || cmd.register_select_low)
        |=> $stable(state_reg.ctrl) && $stable(monitor_channel) && !clear_all_pulse)
        else $error("command taken outside special space");
    a_ctrl_write: assert property (chk_wr_cmd |=> state_reg.ctrl == $past(cmd.data)) // [RL4]
        else $error("control write not stored");
    a_ctrl_read: assert property (chk_rd_cmd // [RL4]
        |=> rd_valid && rd_data == $past(state_reg.ctrl))
        else $error("control readback wrong");
    a_rd_hold: assert property (!chk_rd_cmd // [RL4]
        |=> !rd_valid && $stable(rd_data))
        else $error("readback changed without a read");
    a_mon_select: assert property (chk_mon_cmd // [RL16]
        |=> monitor_channel == $past(cmd.data[11:6]))
        else $error("monitor channel not taken from data 11..6");
    a_mon_route: assert property (monitor_route // [RL10]
        == (cfg.monitor_enable && monitor_channel != DCM_MON_THREE_STATE))
        else $error("monitor route does not follow enable and channel");
    a_mon_hiz: assert property (monitor_output_pin_hiz // [RL18]
        == (cfg.monitor_enable && monitor_channel == DCM_MON_THREE_STATE)
        && !(monitor_output_pin_hiz && monitor_route))
        else $error("monitor three-state inconsistent");
    a_thermal_off: assert property (cfg.thermal_guard_enable && state_reg.hot_sync[1] // [RL11]
        |=> !amps_on)
        else $error("amplifiers not off while hot");
    a_hw_pd_amps: assert property (state_reg.hw_pd_sync[1] |=> !amps_on) // [RL20]
        else $error("amplifiers on during hardware power-down");
    a_pd_write_block: assert property (state_reg.soft_pd && cmd_valid // [RL20]
        && is_cmd(cmd, DCM_CMD_DEVICE_CONTROL) && !cmd.rd_wr
        |=> $stable(state_reg.ctrl))
        else $error("control written during power-down");
    a_pd_mon_block: assert property (state_reg.soft_pd && cmd_valid // [RL20]
        && is_cmd(cmd, DCM_CMD_MONITOR_CHANNEL_SELECT)
        |=> $stable(monitor_channel))
        else $error("monitor select taken during power-down");
    a_clear_single: assert property (clear_all_pulse |=> !clear_all_pulse) // [RL2]
        else $error("clear pulse longer than one cycle");
    a_toggle_flip: assert property (!busy_n // [RL15]
        |=> $stable(toggle_phase) || $past(chk_reset_cmd))
        else $error("toggle moved while busy");

    c_soft_reset: cover property (chk_reset_cmd ##1 !busy_n [*8]);
    c_ctrl_read: cover property (chk_wr_cmd ##[1:20] chk_rd_cmd);
    c_monitor: cover property (chk_mon_cmd ##1 monitor_route);
    c_thermal: cover property (!amps_on && state_reg.thermal_shut);
    c_hw_powerdown: cover property (state_reg.hw_pd_sync[1] ##1 !amps_on ##[1:20] amps_on);

endmodule : dcm_sfr
